// File: include/tape_cmd_consts.svh
// Constants for the tape control command and data register block
`ifndef TAPE_CMD_CONSTS_SVH
`define TAPE_CMD_CONSTS_SVH
`define CMD_TEST_STATUS 9'h100
`define CMD_EMPTY       9'h000
`define CMD_P_BIT       8
`define DR_WIDTH        12
`define DR_USED_LO      4
`define DR_RESET        12'h000
`define CTAG_STEP_LOAD  2'h1
`define CTAG_STEP_BUSY  2'h3
`define TM_PATTERN      8'h00
`define WCLK_TM_A       4'h2
`define WCLK_TM_B       4'h3
`endif

// File: include/tape_cmd_pkg.sv
// Types for the tape control command and data register block
package tape_cmd_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [8:0] cmd_t;
	typedef logic [11:0] dr_t;
endpackage : tape_cmd_pkg

// File: logic/tape_control_command_data_register.sv
// Command register, interlocks, data register and parity for the tape control
// Functional notes
// - Nine-latch command register loaded from bus out
// - Even parity command byte blocks loading
// - Byte to data register, then command load
// - Parity position decodes only test status
// - Busy set at step three, held
// - Busy refuses later command tag loads
// - Gate set when status in clears
// - Service out executes, command tag stacks
// - Stacked: keep motion commands, drop others
// - Counting stop delay holds off gate
// - Decoded starts gated by command gate
// - Unit clear, reset or a dropped command empties register; chain
// - Twelve positions, five to twelve used
// - Information bytes pass through data register
// - Parity bits kept in trap flags
// - Even ones count sets bus out check
// - Odd parity generated toward channel
// - Second circuit checks and makes tape parity
// - Outbound gate only in four cases
// - First service in sets data gate
// - Tape mark loads on clocks two, three
// - Check character loaded once per write
// - Command tag to status stacks unless control
`timescale 1ns/1ps
`default_nettype none
`include "tape_cmd_consts.svh"
module tape_control_command_data_register (
	input  wire logic                  clk_sys,
	input  wire logic                  reset,
	input  wire tape_cmd_pkg::byte_t   bus_out,
	input  wire logic                  bus_out_p,
	input  wire logic                  command_out,
	input  wire logic                  service_out,
	input  wire logic                  address_in,
	input  wire logic                  status_in,
	input  wire logic                  service_in,
	input  wire logic                  adapter_unit_clear,
	input  wire logic                  control_cmd,
	input  wire logic                  tape_unit_counting,
	input  wire logic                  write_op,
	input  wire logic                  tape_mark_write,
	input  wire tape_cmd_pkg::byte_t   tape_mark_bits,
	input  wire logic [3:0]            write_clock,
	input  wire logic                  write_end,
	input  wire tape_cmd_pkg::byte_t   check_char_register,
	input  wire logic                  inbound_load,
	input  wire tape_cmd_pkg::byte_t   inbound_byte,
	input  wire logic                  read_strobe,
	input  wire tape_cmd_pkg::byte_t   read_byte,
	input  wire logic                  read_p,
	output tape_cmd_pkg::cmd_t         command_reg,
	output logic                       command_busy,
	output logic                       command_gate,
	output logic                       start_enable,
	output logic                       test_status_cmd,
	output logic                       stacked_status,
	output logic                       drop_command,
	output tape_cmd_pkg::dr_t          data_register,
	output logic                       data_gate,
	output logic                       bus_out_check,
	output tape_cmd_pkg::byte_t        bus_in,
	output logic                       bus_in_p,
	output logic                       tape_write_p,
	output logic                       vertical_parity_check
);
	import tape_cmd_pkg::*;

	cmd_t        cmd_q;
	logic        busy_q, gate_q, stack_q, dgate_q, chk_q, vrc_q;
	logic        trap_q, tape_trap_q, ccc_done_q, rd_dly_q;
	dr_t         dr_q;
	logic        ctag_q;
	logic [1:0]  step_q;
	logic        initial_sel_q, status_seen_q;
	logic        outbound_gate, cmd_set, tm_pulse, ccc_pulse, odd_ok;
	byte_t       out_byte;

	// Odd parity over eight bits plus parity; true means odd total
	function automatic logic odd9(input byte_t b, input logic p);
		odd9 = ^{b, p};
	endfunction : odd9

	// Command tag delay steps; counts from the tag's rise
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctag_q <= 1'b0;
			step_q <= 2'h0;
		end else begin
			ctag_q <= command_out;
			if (!command_out)
				step_q <= 2'h0;
			else if (step_q != 2'h3)
				step_q <= step_q + 2'h1;
		end
	end

	// Initial selection window: address in seen until status in drops
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			initial_sel_q <= 1'b0;
			status_seen_q <= 1'b0;
		end else begin
			if (address_in && !busy_q)
				initial_sel_q <= 1'b1;
			else if (status_seen_q && !status_in)
				initial_sel_q <= 1'b0;
			if (!initial_sel_q)
				status_seen_q <= 1'b0;
			else if (status_in)
				status_seen_q <= 1'b1;
		end
	end

	// Command set only at step one of an initial-selection tag
	assign cmd_set = initial_sel_q && !busy_q && command_out && !status_in
		&& (step_q == `CTAG_STEP_LOAD);
	assign odd_ok = odd9(dr_q[11:4], trap_q);

	// Command register; unit clear, machine reset or a dropped command empties it
	always_ff @(posedge clk_sys) begin
		if (reset || adapter_unit_clear || drop_command)
			cmd_q <= `CMD_EMPTY;
		else if (cmd_set && odd_ok)
			cmd_q <= {trap_q, bus_out};
	end

	// Busy follows register contents; gate follows busy
	always_ff @(posedge clk_sys) begin
		if (reset || cmd_q == `CMD_EMPTY)
			busy_q <= 1'b0;
		else if (initial_sel_q && command_out && step_q == `CTAG_STEP_BUSY)
			busy_q <= 1'b1;
	end

	// Gate waits for end of selection and stop delay
	always_ff @(posedge clk_sys) begin
		if (reset || !busy_q)
			gate_q <= 1'b0;
		else if (!initial_sel_q && !status_in && !tape_unit_counting && !stack_q)
			gate_q <= 1'b1;
		else if (!initial_sel_q && stack_q && control_cmd && !tape_unit_counting)
			gate_q <= 1'b1;
	end

	// Stack when channel answers initial status with a command tag
	always_ff @(posedge clk_sys) begin
		if (reset || adapter_unit_clear)
			stack_q <= 1'b0;
		else if (initial_sel_q && status_in && command_out && !ctag_q && !control_cmd)
			stack_q <= 1'b1;
	end

	// Stacked non-motion commands are abandoned
	assign drop_command = stack_q && !control_cmd && busy_q;

	// Data gate set by first service in of a write
	always_ff @(posedge clk_sys) begin
		if (reset || !write_op)
			dgate_q <= 1'b0;
		else if (service_in)
			dgate_q <= 1'b1;
	end

	// Check character once per write; flag rearms when the write ends
	always_ff @(posedge clk_sys) begin
		if (reset || !write_op)
			ccc_done_q <= 1'b0;
		else if (ccc_pulse)
			ccc_done_q <= 1'b1;
	end

	assign tm_pulse  = tape_mark_write && (write_clock == `WCLK_TM_A
		|| write_clock == `WCLK_TM_B);
	assign ccc_pulse = write_op && write_end && !ccc_done_q;
	// Outbound gate restricted to its four sources
	assign outbound_gate = (dgate_q && write_op && service_out) || tm_pulse
		|| (initial_sel_q && command_out && !ctag_q && !busy_q) || ccc_pulse;
	// Tape mark suppresses positions without a one bit
	assign out_byte = tm_pulse ? (bus_out & tape_mark_bits) : bus_out;

	// Data register, low positions unused without conversion
	always_ff @(posedge clk_sys) begin
		if (reset)
			dr_q <= `DR_RESET;
		else if (ccc_pulse)
			dr_q <= {check_char_register, 4'h0};
		else if (outbound_gate)
			dr_q <= {out_byte, 4'h0};
		else if (inbound_load)
			dr_q <= {inbound_byte, 4'h0};
		else if (read_strobe)
			dr_q <= {read_byte, 4'h0};
	end

	// Trap flags keep parity bits out of the data register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			trap_q      <= 1'b0;
			tape_trap_q <= 1'b0;
		end else begin
			if (outbound_gate && !ccc_pulse)
				trap_q <= bus_out_p;
			if (read_strobe)
				tape_trap_q <= read_p;
		end
	end

	// Bus out check on even total of channel byte
	always_ff @(posedge clk_sys) begin
		if (reset || adapter_unit_clear)
			chk_q <= 1'b0;
		else if (!odd9(dr_q[11:4], trap_q) && !ccc_pulse && status_seen_q == 1'b0
			&& ctag_q == 1'b0 && outbound_gate == 1'b0 && dgate_q)
			chk_q <= 1'b1;
	end

	// Strobe delayed so the check sees the byte already in the register
	always_ff @(posedge clk_sys) begin
		if (reset)
			rd_dly_q <= 1'b0;
		else
			rd_dly_q <= read_strobe;
	end

	// Read vertical parity checked one cycle after each tape byte
	always_ff @(posedge clk_sys) begin
		if (reset || adapter_unit_clear)
			vrc_q <= 1'b0;
		else if (rd_dly_q && !odd9(dr_q[11:4], tape_trap_q))
			vrc_q <= 1'b1;
	end

	assign command_reg     = cmd_q;
	assign command_busy    = busy_q;
	assign command_gate    = gate_q;
	assign start_enable    = gate_q && busy_q;
	// Parity position only used for the test status code
	assign test_status_cmd = (cmd_q == `CMD_TEST_STATUS);
	assign stacked_status  = stack_q;
	assign data_register   = dr_q;
	assign data_gate       = dgate_q;
	assign bus_out_check   = chk_q;
	assign bus_in          = dr_q[11:4];
	assign bus_in_p        = ~^dr_q[11:4];
	assign tape_write_p    = ~^dr_q[11:4];
	assign vertical_parity_check = vrc_q;

	a_busy_needs_cmd: assert property (@(posedge clk_sys) disable iff (reset)
		busy_q |-> cmd_q != `CMD_EMPTY || $past(cmd_q) != `CMD_EMPTY)
		else $error("busy without command");
	a_gate_needs_busy: assert property (@(posedge clk_sys) disable iff (reset)
		gate_q |-> $past(busy_q))
		else $error("gate without busy");
	a_even_blocks: assert property (@(posedge clk_sys) disable iff (reset)
		(cmd_set && !odd_ok && !adapter_unit_clear && cmd_q == `CMD_EMPTY)
		|=> cmd_q == `CMD_EMPTY)
		else $error("even parity loaded");
	a_busy_refuses: assert property (@(posedge clk_sys) disable iff (reset)
		(busy_q && !adapter_unit_clear && !drop_command) |=> cmd_q == $past(cmd_q))
		else $error("load while busy");
	a_counting_holds: assert property (@(posedge clk_sys) disable iff (reset)
		(!gate_q && tape_unit_counting) |=> !gate_q)
		else $error("gate during stop delay");
	a_start_gated: assert property (@(posedge clk_sys) disable iff (reset)
		start_enable |-> command_gate)
		else $error("start without gate");
	a_inbound_odd: assert property (@(posedge clk_sys) disable iff (reset)
		^{bus_in, bus_in_p} == 1'b1)
		else $error("inbound parity not odd");
	a_ccc_once: assert property (@(posedge clk_sys) disable iff (reset)
		ccc_pulse |=> !ccc_pulse)
		else $error("check char twice");
	a_clear_empties: assert property (@(posedge clk_sys) disable iff (reset)
		adapter_unit_clear |=> cmd_q == `CMD_EMPTY ##1 !busy_q)
		else $error("clear did not empty");

	// Command byte and trapped parity land together
	a_cmd_load_val: assert property (@(posedge clk_sys) disable iff (reset)
		(cmd_set && odd_ok && !adapter_unit_clear) |=> cmd_q[7:0] == $past(bus_out) && cmd_q[8] == $past(trap_q))
		else $error("command byte not loaded");

	// A new command only ever comes from the step one load
	a_load_needs_step: assert property (@(posedge clk_sys) disable iff (reset)
		($changed(cmd_q) && cmd_q != `CMD_EMPTY) |-> $past(cmd_set))
		else $error("command loaded outside step one");

	// Tag rise copies the byte into the data register first
	a_dr_on_tag: assert property (@(posedge clk_sys) disable iff (reset)
		(initial_sel_q && command_out && !ctag_q && !busy_q && !ccc_pulse && !tm_pulse)
		|=> dr_q[11:4] == $past(bus_out))
		else $error("command byte missed data register");

	// Busy must rise at step three once a command is held
	a_busy_at_step: assert property (@(posedge clk_sys) disable iff (reset)
		(initial_sel_q && command_out && step_q == `CTAG_STEP_BUSY && cmd_q != `CMD_EMPTY) |=> busy_q)
		else $error("busy late");

	// Gate only after the selection window has closed
	a_gate_after_sel: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(gate_q) |-> !$past(initial_sel_q) && $past(busy_q))
		else $error("gate inside selection");

	// Stop delay in progress never lets the gate rise
	a_gate_counting: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(gate_q) |-> !$past(tape_unit_counting))
		else $error("gate rose while counting");

	// Stack only on a tag during status, never for control
	a_stack_no_ctl: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(stack_q) |-> !$past(control_cmd) && $past(status_in))
		else $error("stack without cause");

	// Abandoned commands leave the register next cycle
	a_drop_clears: assert property (@(posedge clk_sys) disable iff (reset)
		drop_command |=> cmd_q == `CMD_EMPTY)
		else $error("dropped command kept");

	// Empty register takes busy down
	a_busy_drops: assert property (@(posedge clk_sys) disable iff (reset)
		(cmd_q == `CMD_EMPTY) |=> !busy_q)
		else $error("busy with empty register");

	// Busy low takes gate down
	a_gate_drops: assert property (@(posedge clk_sys) disable iff (reset)
		!busy_q |=> !gate_q)
		else $error("gate without busy");

	// Data gate needs a service in during a write
	a_dgate_first: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(dgate_q) |-> $past(service_in) && $past(write_op))
		else $error("data gate without service in");

	// Tape mark leaves only its own one bits
	a_tm_suppress: assert property (@(posedge clk_sys) disable iff (reset)
		(tm_pulse && !ccc_pulse) |=> (dr_q[11:4] & ~$past(tape_mark_bits)) == 8'h00)
		else $error("tape mark bit leaked");

	// Check character lands in the used positions
	a_ccc_load: assert property (@(posedge clk_sys) disable iff (reset)
		ccc_pulse |=> dr_q[11:4] == $past(check_char_register))
		else $error("check char not loaded");

	// Feature positions stay empty without conversion
	a_low_dr_zero: assert property (@(posedge clk_sys) disable iff (reset)
		dr_q[3:0] == 4'h0)
		else $error("unused positions set");

	// Channel parity bit goes to the trap, not the register
	a_trap_follows: assert property (@(posedge clk_sys) disable iff (reset)
		(outbound_gate && !ccc_pulse) |=> trap_q == $past(bus_out_p))
		else $error("parity trap missed");

	// Tape write parity is odd over the byte
	a_tape_p_odd: assert property (@(posedge clk_sys) disable iff (reset)
		^{dr_q[11:4], tape_write_p} == 1'b1)
		else $error("tape parity not odd");

	// Machine reset empties the command and data registers and clears the trap and busy
	a_reset_clears: assert property (@(posedge clk_sys)
		reset |=> cmd_q == `CMD_EMPTY && dr_q == `DR_RESET && !trap_q && !busy_q)
		else $error("reset left state");
endmodule : tape_control_command_data_register
`default_nettype wire

// File: test/channel_model.sv
// Channel side model driving bus out and the outbound tag lines
`timescale 1ns/1ps
`default_nettype none
module channel_model (
	input  wire logic           clk_sys,
	output tape_cmd_pkg::byte_t bus_out,
	output logic                bus_out_p,
	output logic                address_in,
	output logic                command_out,
	output logic                status_in,
	output logic                service_out
);
	import tape_cmd_pkg::*;
	// Quiet interface until the first request
	initial {bus_out, bus_out_p, address_in, command_out, status_in, service_out} = '0;
	// Byte under a tag held four cycles; selection adds the status answer
	task automatic send(input byte_t b, input logic p, input logic sel, input logic stack,
		input logic wr);
		@(posedge clk_sys) address_in <= sel;
		bus_out <= b;
		bus_out_p <= p;
		@(posedge clk_sys) command_out <= !wr;
		service_out <= wr;
		repeat (4) @(posedge clk_sys);
		command_out <= 1'b0;
		service_out <= 1'b0;
		address_in <= 1'b0;
		bus_out <= ~b; // Released bus must not keep the old byte
		bus_out_p <= ~p;
		if (sel) begin
			@(posedge clk_sys) status_in <= 1'b1;
			@(posedge clk_sys) command_out <= stack;
			service_out <= !stack;
			@(posedge clk_sys) status_in <= 1'b0;
			command_out <= 1'b0;
			service_out <= 1'b0;
		end
	endtask : send
endmodule : channel_model
`default_nettype wire

// File: test/tape_control_command_data_register_tb_top.sv
// Self-checking bench for the tape control command and data register block
`timescale 1ns/1ps
`default_nettype none
module tape_control_command_data_register_tb_top;
	import tape_cmd_pkg::*;
	localparam logic [5:0] bad_v = 6'h02, stk_v = 6'h18, ctl_v = 6'h10, cnt_v = 6'h04;
	logic  clk_sys, reset, service_in, adapter_unit_clear, control_cmd, tape_unit_counting;
	logic  write_op, tape_mark_write, write_end, inbound_load, read_strobe, read_p, live;
	logic  bus_out_p, command_out, service_out, address_in, status_in, command_busy;
	logic  command_gate, start_enable, test_status_cmd, stacked_status, data_gate;
	logic  bus_out_check, bus_in_p, tape_write_p, vertical_parity_check, drop_command;
	logic  [3:0] write_clock;
	byte_t bus_out, tape_mark_bits, check_char_register, inbound_byte, read_byte, b, bus_in;
	cmd_t  command_reg, last_cmd, exp_q[$];
	dr_t   data_register;
	int    fail_count, n_tests, i;
	tape_control_command_data_register dut_u (.clk_sys, .reset, .bus_out, .bus_out_p,
		.command_out, .service_out, .address_in, .status_in, .service_in, .adapter_unit_clear,
		.control_cmd, .tape_unit_counting, .write_op, .tape_mark_write, .tape_mark_bits,
		.write_clock, .write_end, .check_char_register, .inbound_load, .inbound_byte,
		.read_strobe, .read_byte, .read_p, .command_reg, .command_busy, .command_gate,
		.start_enable, .test_status_cmd, .stacked_status, .drop_command, .data_register,
		.data_gate, .bus_out_check, .bus_in, .bus_in_p, .tape_write_p, .vertical_parity_check);
	channel_model chan_u (.clk_sys, .bus_out, .bus_out_p, .address_in, .command_out,
		.status_in, .service_out);
	// 100 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Settle point just after an edge, so sampling never races the design
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : wait_n
	task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_val
	task automatic cmp_flag(input logic got, input logic exp);
		cmp_val({11'h0, got}, {11'h0, exp});
	endtask : cmp_flag
	task automatic print_verdict();
		$display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// Every new command register value takes the oldest noted command
	always @(posedge clk_sys) begin
		if (!reset && command_reg !== last_cmd && command_reg !== 9'h000) begin
			if (exp_q.size() == 0) cmp_val({3'h0, command_reg}, 12'hfff);
			else cmp_val({3'h0, command_reg}, {3'h0, exp_q.pop_front()});
		end
		last_cmd = command_reg;
	end
	// Hang guard, far beyond the expected run of under two hundred cycles
	initial begin
		repeat (4000) @(posedge clk_sys);
		fail_count++;
		print_verdict();
	end
	// Selection cases first, then the write and tape read paths
	initial begin
		{reset, service_in, adapter_unit_clear, control_cmd, tape_unit_counting} = 5'h10;
		{write_op, tape_mark_write, write_end, inbound_load, read_strobe, read_p} = '0;
		{write_clock, tape_mark_bits, check_char_register, inbound_byte, read_byte} = '0;
		last_cmd = '0;
		void'($urandom(38));
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		wait_n(1);
		cmp_val(data_register, 12'h000);
		for (i = 0; i < 6; i++) begin
			b = (i == 0) ? 8'h00 : 8'($urandom);
			live = !bad_v[i] && !(stk_v[i] && !ctl_v[i]);
			@(posedge clk_sys) control_cmd <= ctl_v[i];
			tape_unit_counting <= cnt_v[i];
			if (!bad_v[i]) exp_q.push_back({~^b, b});
			chan_u.send(b, bad_v[i] ^ ~^b, 1'b1, stk_v[i], 1'b0);
			wait_n(3);
			cmp_flag(command_busy, live);
			cmp_flag(command_gate, live && !cnt_v[i]);
			cmp_flag(stacked_status, stk_v[i] && !ctl_v[i]);
			cmp_flag(test_status_cmd, live && i == 0);
			cmp_flag(start_enable && !command_gate, 1'b0);
			cmp_flag(bus_in_p, ~^b);
			cmp_val({4'h0, bus_in}, {4'h0, b});
			if (!stk_v[i]) cmp_val(data_register, {b, 4'h0});
			chan_u.send(~b, ~^b, 1'b0, 1'b0, 1'b0);
			@(posedge clk_sys) adapter_unit_clear <= 1'b1;
			@(posedge clk_sys) adapter_unit_clear <= 1'b0;
			wait_n(3);
			cmp_flag(command_busy | command_gate | stacked_status, 1'b0);
			cmp_val({3'h0, command_reg}, 12'h000);
			cmp_flag(drop_command, 1'b0);
		end
		@(posedge clk_sys) write_op <= 1'b1;
		service_in <= 1'b1;
		@(posedge clk_sys) service_in <= 1'b0;
		wait_n(1);
		cmp_flag(data_gate, 1'b1);
		for (i = 0; i < 2; i++) begin
			b = 8'($urandom);
			chan_u.send(b, i[0] ^ ~^b, 1'b0, 1'b0, 1'b1);
			wait_n(1);
			cmp_val(data_register, {b, 4'h0});
			cmp_flag(bus_out_check, i[0]);
		end
		b = 8'($urandom);
		@(posedge clk_sys) check_char_register <= b;
		write_end <= 1'b1;
		read_byte <= ~b;
		read_p <= ^b; // Even total, a tape parity fault
		@(posedge clk_sys) write_end <= 1'b0;
		write_op <= 1'b0;
		#1;
		cmp_val(data_register, {b, 4'h0});
		cmp_flag(tape_write_p, ~^b);
		@(posedge clk_sys) read_strobe <= 1'b1;
		@(posedge clk_sys) read_strobe <= 1'b0;
		wait_n(1);
		cmp_flag(vertical_parity_check, 1'b1);
		b = 8'($urandom);
		@(posedge clk_sys) tape_mark_write <= 1'b1;
		write_clock <= 4'h2;
		tape_mark_bits <= b;
		@(posedge clk_sys) tape_mark_write <= 1'b0;
		write_clock <= 4'h0;
		#1;
		cmp_val(data_register, {chan_u.bus_out & b, 4'h0});
		@(posedge clk_sys) inbound_load <= 1'b1;
		inbound_byte <= ~b;
		@(posedge clk_sys) inbound_load <= 1'b0;
		#1;
		cmp_val({4'h0, bus_in}, {4'h0, ~b});
		cmp_flag(bus_in_p, ~^b);
		cmp_val(12'(exp_q.size()), 12'h000);
		print_verdict();
	end
endmodule : tape_control_command_data_register_tb_top
`default_nettype wire
